// file: src/cip_defs.svh
/*
 Constants for the inbound receive path: storage size, word layout,
 frame header fields and queue indices.
 Assumes it is included by bare name before the package and the module.
*/
`ifndef CIP_DEFS_SVH
`define CIP_DEFS_SVH

`define CIP_DEPTH 9'h100
`define CIP_PTR_W 8
`define CIP_CNT_W 9
`define CIP_LINK_W 32
`define CIP_WORD_W 36
`define CIP_EOF_BIT 35
`define CIP_SOF_BIT 34
`define CIP_RDY_DATA_BIT 31
`define CIP_RDY_CTRL_BIT 30
`define CIP_TYPE_HI 29
`define CIP_TYPE_LO 26
`define CIP_TYPE_IDLE 4'h0
`define CIP_TYPE_DATA_MAX 4'h5
`define CIP_Q_DATA 0
`define CIP_Q_CTRL 1
`define CIP_VACC_RST 32'h0000_0000

`endif

// file: src/cip_pkg.sv
/*
 Types shared by the inbound receive path.
 Assumes cip_defs.svh is on the include path.
*/
`include "cip_defs.svh"

package cip_pkg;
	typedef logic [`CIP_WORD_W-1:0] cip_word_t;
	typedef logic [`CIP_LINK_W-1:0] cip_link_t;
	typedef logic [`CIP_CNT_W-1:0] cip_cnt_t;
	typedef logic [`CIP_PTR_W-1:0] cip_ptr_t;
	typedef logic [3:0] cip_type_t;
endpackage

// file: src/cip_inbound_path.sv
/*
 Inbound receive path of one 32-bit frame link: sorts frames into a data
 and a control queue, drops idle frames, checks parity and offers two
 read buses.
 Assumes the link clock, link pins and read-bus pins come from outside the
 clk domain and are slow enough to be sampled (edges found by clk).
*/
`timescale 1ns/1ps
`include "cip_defs.svh"

module cip_inbound_path
	import cip_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic link_clock,
	input wire logic [`CIP_LINK_W-1:0] link_rx_word,
	input wire logic link_rx_sof,
	input wire logic link_rx_check_bit,
	input wire logic hpar_check_en,
	input wire logic vpar_check_en,
	input wire logic [`CIP_CNT_W-1:0] data_low_mark,
	input wire logic [`CIP_CNT_W-1:0] data_high_mark,
	input wire logic [`CIP_CNT_W-1:0] ctrl_low_mark,
	input wire logic [`CIP_CNT_W-1:0] ctrl_high_mark,
	input wire logic ob_data_nearly_full,
	input wire logic ob_ctrl_nearly_full,
	input wire logic inq_read_clock_dat,
	input wire logic inq_pull_en_dat,
	output logic [`CIP_WORD_W-1:0] inq_word_bus_dat,
	output logic inq_frame_present_n_dat,
	output logic inq_drained_flag_dat,
	input wire logic inq_read_clock_ctl,
	input wire logic inq_pull_en_ctl,
	output logic [`CIP_WORD_W-1:0] inq_word_bus_ctl,
	output logic inq_frame_present_n_ctl,
	output logic inq_drained_flag_ctl,
	output logic local_data_ready,
	output logic local_ctrl_ready,
	output logic ib_data_nearly_full,
	output logic ib_ctrl_nearly_full,
	output logic data_overflow_err,
	output logic data_underflow_err,
	output logic ctrl_overflow_err,
	output logic ctrl_underflow_err,
	output logic hpar_err,
	output logic vpar_err
);

	function automatic logic q_of(input cip_type_t t);
		q_of = (t > `CIP_TYPE_DATA_MAX);
	endfunction

	// Pin synchronisers
	logic [34:0] lsy1_r, lsy2_r, lsy1_nxt;
	logic lclk_prev_r, lk_edge;
	logic [3:0] rsy1_r, rsy2_r, rsy1_nxt;
	logic [1:0] rclk_prev_r;
	logic [1:0] rd_edge, pull;

	// Link pipeline
	cip_link_t s1_word_r, s1_word_nxt, s2_word_r, s2_word_nxt, vacc_r, vacc_nxt;
	logic s1_sof_r, s1_sof_nxt, s1_chk_r, s1_chk_nxt, s1_vld_r, s1_vld_nxt;
	logic s2_sof_r, s2_sof_nxt, s2_vld_r, s2_vld_nxt;
	logic s2_q_r, s2_q_nxt, s2_idle_r, s2_idle_nxt;
	logic [1:0] rdy_r, rdy_nxt, lrdy_r, lrdy_nxt, wr_req;
	logic hpar_r, hpar_nxt, vpar_r, vpar_nxt;
	cip_word_t wr_word;
	cip_type_t s1_type;

	// Queues
	cip_word_t mem [2][256];
	cip_ptr_t wptr_r [2], wptr_nxt [2], rptr_r [2], rptr_nxt [2];
	cip_cnt_t cnt_r [2], cnt_nxt [2], low [2], high [2];
	cip_word_t bus_r [2], bus_nxt [2], head [2];
	logic [1:0] wr_ok, rd_req, rd_ok;
	logic [1:0] fpn_r, fpn_nxt, drn_r, drn_nxt, nf_r, nf_nxt;
	logic [1:0] ovf_r, ovf_nxt, udf_r, udf_nxt;

	assign low[`CIP_Q_DATA] = data_low_mark;
	assign low[`CIP_Q_CTRL] = ctrl_low_mark;
	assign high[`CIP_Q_DATA] = data_high_mark;
	assign high[`CIP_Q_CTRL] = ctrl_high_mark;

	// Only second stages and the edge flops are read by logic
	assign lk_edge = lsy2_r[34] & ~lclk_prev_r;
	assign rd_edge = rsy2_r[1:0] & ~rclk_prev_r;
	assign pull = rsy2_r[3:2];
	assign s1_type = s1_word_r[`CIP_TYPE_HI:`CIP_TYPE_LO];

	always_comb begin
		lsy1_nxt = {link_clock, link_rx_sof, link_rx_check_bit, link_rx_word};
		rsy1_nxt = {inq_pull_en_ctl, inq_pull_en_dat, inq_read_clock_ctl, inq_read_clock_dat};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lsy1_r <= '0;
			lsy2_r <= '0;
			lclk_prev_r <= 1'b0;
			rsy1_r <= '0;
			rsy2_r <= '0;
			rclk_prev_r <= '0;
		end else if (clk_en) begin
			lsy1_r <= lsy1_nxt;
			lsy2_r <= lsy1_r;
			lclk_prev_r <= lsy2_r[34];
			rsy1_r <= rsy1_nxt;
			rsy2_r <= rsy1_r;
			rclk_prev_r <= rsy2_r[1:0];
		end
	end

	always_comb begin
		s1_word_nxt = s1_word_r;
		s1_sof_nxt = s1_sof_r;
		s1_chk_nxt = s1_chk_r;
		s1_vld_nxt = s1_vld_r;
		s2_word_nxt = s2_word_r;
		s2_sof_nxt = s2_sof_r;
		s2_vld_nxt = s2_vld_r;
		s2_q_nxt = s2_q_r;
		s2_idle_nxt = s2_idle_r;
		rdy_nxt = rdy_r;
		vacc_nxt = vacc_r;
		hpar_nxt = 1'b0;
		vpar_nxt = 1'b0;
		wr_req = 2'b00;
		// Next word's start flag closes the word leaving stage two
		wr_word = {s1_sof_r, s2_sof_r, 2'b00, s2_word_r};
		if (lk_edge) begin
			s1_word_nxt = lsy2_r[31:0];
			s1_chk_nxt = lsy2_r[32];
			s1_sof_nxt = lsy2_r[33];
			s1_vld_nxt = 1'b1;
			if (s2_vld_r && !s2_idle_r) begin
				wr_req[s2_q_r] = 1'b1;
			end
			if (s1_vld_r) begin
				s2_word_nxt = s1_word_r;
				s2_sof_nxt = s1_sof_r;
				s2_vld_nxt = s1_sof_r | s2_vld_r;
				if (s1_sof_r) begin
					s2_q_nxt = q_of(s1_type);
					s2_idle_nxt = (s1_type == `CIP_TYPE_IDLE);
					rdy_nxt = {s1_word_r[`CIP_RDY_CTRL_BIT], s1_word_r[`CIP_RDY_DATA_BIT]};
					vpar_nxt = vpar_check_en && s2_vld_r && (vacc_r != `CIP_VACC_RST);
					vacc_nxt = s1_word_r;
				end else begin
					vacc_nxt = vacc_r ^ s1_word_r;
				end
				hpar_nxt = hpar_check_en && !(^{s1_word_r, s1_chk_r});
			end
		end
		lrdy_nxt = rdy_nxt & ~{ob_ctrl_nearly_full, ob_data_nearly_full};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_word_r <= '0;
			s1_sof_r <= 1'b0;
			s1_chk_r <= 1'b0;
			s1_vld_r <= 1'b0;
			s2_word_r <= '0;
			s2_sof_r <= 1'b0;
			s2_vld_r <= 1'b0;
			s2_q_r <= 1'b0;
			s2_idle_r <= 1'b1;
			rdy_r <= 2'b00;
			lrdy_r <= 2'b00;
			vacc_r <= '0;
			hpar_r <= 1'b0;
			vpar_r <= 1'b0;
		end else if (clk_en) begin
			s1_word_r <= s1_word_nxt;
			s1_sof_r <= s1_sof_nxt;
			s1_chk_r <= s1_chk_nxt;
			s1_vld_r <= s1_vld_nxt;
			s2_word_r <= s2_word_nxt;
			s2_sof_r <= s2_sof_nxt;
			s2_vld_r <= s2_vld_nxt;
			s2_q_r <= s2_q_nxt;
			s2_idle_r <= s2_idle_nxt;
			rdy_r <= rdy_nxt;
			lrdy_r <= lrdy_nxt;
			vacc_r <= vacc_nxt;
			hpar_r <= hpar_nxt;
			vpar_r <= vpar_nxt;
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			head[i] = mem[i][rptr_r[i]];
			wr_ok[i] = wr_req[i] && (cnt_r[i] != `CIP_DEPTH);
			rd_req[i] = rd_edge[i] && pull[i];
			rd_ok[i] = rd_req[i] && (cnt_r[i] != '0);
			cnt_nxt[i] = cnt_r[i] + cip_cnt_t'(wr_ok[i]) - cip_cnt_t'(rd_ok[i]);
			wptr_nxt[i] = wptr_r[i] + cip_ptr_t'(wr_ok[i]);
			rptr_nxt[i] = rptr_r[i] + cip_ptr_t'(rd_ok[i]);
			bus_nxt[i] = rd_ok[i] ? head[i] : bus_r[i];
			ovf_nxt[i] = wr_req[i] && !wr_ok[i];
			udf_nxt[i] = rd_req[i] && !rd_ok[i];
			fpn_nxt[i] = !(cnt_nxt[i] > low[i]);
			drn_nxt[i] = (cnt_nxt[i] == '0);
			nf_nxt[i] = (cnt_nxt[i] > high[i]);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 2; i++) begin
				wptr_r[i] <= '0;
				rptr_r[i] <= '0;
				cnt_r[i] <= '0;
				bus_r[i] <= '0;
			end
			fpn_r <= 2'b11;
			drn_r <= 2'b11;
			nf_r <= 2'b00;
			ovf_r <= 2'b00;
			udf_r <= 2'b00;
		end else if (clk_en) begin
			for (int i = 0; i < 2; i++) begin
				wptr_r[i] <= wptr_nxt[i];
				rptr_r[i] <= rptr_nxt[i];
				cnt_r[i] <= cnt_nxt[i];
				bus_r[i] <= bus_nxt[i];
			end
			fpn_r <= fpn_nxt;
			drn_r <= drn_nxt;
			nf_r <= nf_nxt;
			ovf_r <= ovf_nxt;
			udf_r <= udf_nxt;
		end
	end

	// Storage has no reset; occupancy guards every read
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (clk_en && wr_ok[i]) begin
				mem[i][wptr_r[i]] <= wr_word;
			end
		end
	end

	always_comb begin
		inq_word_bus_dat = bus_r[`CIP_Q_DATA];
		inq_word_bus_ctl = bus_r[`CIP_Q_CTRL];
		inq_frame_present_n_dat = fpn_r[`CIP_Q_DATA];
		inq_frame_present_n_ctl = fpn_r[`CIP_Q_CTRL];
		inq_drained_flag_dat = drn_r[`CIP_Q_DATA];
		inq_drained_flag_ctl = drn_r[`CIP_Q_CTRL];
		ib_data_nearly_full = nf_r[`CIP_Q_DATA];
		ib_ctrl_nearly_full = nf_r[`CIP_Q_CTRL];
		data_overflow_err = ovf_r[`CIP_Q_DATA];
		ctrl_overflow_err = ovf_r[`CIP_Q_CTRL];
		data_underflow_err = udf_r[`CIP_Q_DATA];
		ctrl_underflow_err = udf_r[`CIP_Q_CTRL];
		local_data_ready = lrdy_r[`CIP_Q_DATA];
		local_ctrl_ready = lrdy_r[`CIP_Q_CTRL];
		hpar_err = hpar_r;
		vpar_err = vpar_r;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_idle_drop;
		clk_en && lk_edge && s2_vld_r && s2_idle_r |-> wr_req == 2'b00;
	endproperty
	a_idle_drop: assert property (p_idle_drop) else $error("idle frame written");
	property p_hpar_off;
		clk_en && lk_edge && s1_vld_r && !hpar_check_en |=> !hpar_err;
	endproperty
	a_hpar_off: assert property (p_hpar_off) else $error("parity error while check off");
	property p_hpar_on;
		clk_en && lk_edge && s1_vld_r && hpar_check_en && !(^{s1_word_r, s1_chk_r}) |=> hpar_err;
	endproperty
	a_hpar_on: assert property (p_hpar_on) else $error("even parity word not flagged");
	property p_lrdy;
		clk_en && ob_data_nearly_full |=> !local_data_ready;
	endproperty
	a_lrdy: assert property (p_lrdy) else $error("local data ready kept high");
	for (genvar g = 0; g < 2; g++) begin : g_chk
		property p_sort;
			clk_en && wr_req[g] |-> s2_q_r == 1'(g) && s2_vld_r;
		endproperty
		a_sort: assert property (p_sort) else $error("frame in wrong queue");
		property p_eof;
			clk_en && wr_ok[g] |=> mem[g][$past(wptr_r[g])][`CIP_EOF_BIT] == $past(s1_sof_r);
		endproperty
		a_eof: assert property (p_eof) else $error("end flag wrong");
		property p_present;
			clk_en |=> fpn_r[g] == !(cnt_r[g] > $past(low[g]));
		endproperty
		a_present: assert property (p_present) else $error("frame present wrong");
		property p_nfull;
			clk_en |=> nf_r[g] == (cnt_r[g] > $past(high[g]));
		endproperty
		a_nfull: assert property (p_nfull) else $error("nearly full wrong");
		property p_ovf;
			clk_en && wr_req[g] && !rd_ok[g] && cnt_r[g] == `CIP_DEPTH |=> ovf_r[g] && cnt_r[g] == `CIP_DEPTH;
		endproperty
		a_ovf: assert property (p_ovf) else $error("overflow not flagged");
		property p_read;
			clk_en && rd_ok[g] |=> bus_r[g] == $past(head[g]) && rptr_r[g] == $past(rptr_r[g]) + 8'h01;
		endproperty
		a_read: assert property (p_read) else $error("word not delivered");
		property p_drained;
			drn_r[g] == (cnt_r[g] == '0);
		endproperty
		a_drained: assert property (p_drained) else $error("drained flag wrong");
	end
endmodule

// file: dv/cip_link_model.sv
/*
 Behavioural frame transmitter on the far side of the inbound link.
 Assumes the bench calls send_word; the link clock only toggles per word.
*/
`timescale 1ns/1ps
`include "cip_defs.svh"
module cip_link_model (
	output logic link_clock,
	output logic [`CIP_LINK_W-1:0] link_rx_word,
	output logic link_rx_sof,
	output logic link_rx_check_bit
);
	initial begin
		link_clock = 1'b0;
		link_rx_word = 32'h0;
		link_rx_sof = 1'b0;
		link_rx_check_bit = 1'b0;
	end
	task automatic send_word(input logic [31:0] w, input logic s, input logic bad);
		// Every change lands 5 ns off a bench clock edge; 400 ns per word
		#5;
		link_rx_word = w;
		link_rx_sof = s;
		link_rx_check_bit = ~(^w) ^ bad;
		#200 link_clock = 1'b1;
		#150 link_clock = 1'b0;
		// Hold time over: show changed values
		link_rx_word = ~w;
		link_rx_sof = ~s;
		link_rx_check_bit = ~link_rx_check_bit;
		#45;
	endtask
endmodule

// file: dv/cip_inbound_path_tb.sv
/*
 Self-checking bench for the inbound receive path.
 Assumes cip_link_model drives the link and the bench makes both read clocks.
*/
`timescale 1ns/1ps
`include "cip_defs.svh"
module cip_inbound_path_tb;
	import cip_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, hen = 1'b1, ven = 1'b1, clr = 1'b0;
	logic [8:0] dlo = 9'h2, dhi = 9'h2, clo = 9'h2, chi = 9'h4;
	logic [1:0] obnf = 2'b00, rclk = 2'b00, pen = 2'b00, pn, dr, lrdy, nf;
	logic lclk, lsof, lchk;
	logic [31:0] lword;
	cip_word_t wb0, wb1;
	logic [5:0] errs, seen = 6'h00;
	cip_word_t dq[$], cq[$];
	int bad_count = 0, n_checks = 0;
	always #25 clk = ~clk;
	cip_link_model lnk (.link_clock(lclk), .link_rx_word(lword), .link_rx_sof(lsof), .link_rx_check_bit(lchk));
	cip_inbound_path uut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .link_clock(lclk),
		.link_rx_word(lword), .link_rx_sof(lsof), .link_rx_check_bit(lchk),
		.hpar_check_en(hen), .vpar_check_en(ven), .data_low_mark(dlo), .data_high_mark(dhi),
		.ctrl_low_mark(clo), .ctrl_high_mark(chi), .ob_data_nearly_full(obnf[0]),
		.ob_ctrl_nearly_full(obnf[1]), .inq_read_clock_dat(rclk[0]), .inq_pull_en_dat(pen[0]),
		.inq_word_bus_dat(wb0), .inq_frame_present_n_dat(pn[0]), .inq_drained_flag_dat(dr[0]),
		.inq_read_clock_ctl(rclk[1]), .inq_pull_en_ctl(pen[1]), .inq_word_bus_ctl(wb1),
		.inq_frame_present_n_ctl(pn[1]), .inq_drained_flag_ctl(dr[1]),
		.local_data_ready(lrdy[0]), .local_ctrl_ready(lrdy[1]),
		.ib_data_nearly_full(nf[0]), .ib_ctrl_nearly_full(nf[1]),
		.data_overflow_err(errs[5]), .data_underflow_err(errs[4]), .ctrl_overflow_err(errs[3]),
		.ctrl_underflow_err(errs[2]), .hpar_err(errs[1]), .vpar_err(errs[0]));
	// Error pulses collected until cleared
	always @(posedge clk) seen <= clr ? 6'h00 : (seen | errs);
	task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
		// Compare made mid-cycle; the outputs were taken when the task was called
		@(negedge clk);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic frame(input logic [3:0] typ, input logic [1:0] rdy, input int n, input bit hb, input bit vb);
		logic [31:0] w, acc;
		acc = 32'h0;
		for (int i = 0; i < n; i++) begin
			w = (i == 0) ? {rdy, typ, 26'h0} : (i == n - 1) ? (acc ^ {31'h0, vb}) : 32'h0a00_0000 + i;
			acc = acc ^ w;
			lnk.send_word(w, i == 0, hb && i == 1);
			if (typ != 4'h0 && typ <= 4'h5)
				dq.push_back({i == n - 1, i == 0, 2'b00, w});
			else if (typ != 4'h0)
				cq.push_back({i == n - 1, i == 0, 2'b00, w});
		end
		frame_idle(rdy);
	endtask
	// Idle frame repeats the ready bits; its words XOR to zero
	task automatic frame_idle(input logic [1:0] rdy);
		for (int i = 0; i < 3; i++)
			lnk.send_word((i == 1) ? 32'h0 : {rdy, 30'h0}, i == 0, 1'b0);
		repeat (8) @(posedge clk);
	endtask
	task automatic rtick(input int q, input logic en);
		@(posedge clk) pen[q] <= en;
		repeat (4) @(posedge clk);
		rclk[q] <= 1'b1;
		repeat (4) @(posedge clk);
		rclk[q] <= 1'b0;
		pen[q] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic clear_seen;
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
	endtask
	initial begin
		#2000000;
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (17) @(posedge clk);
		chk("drained", dr, 2'b11);
		chk("present_n", pn, 2'b11);
		chk("ready_nf", {lrdy, nf}, 4'h0);
		@(posedge clk) reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		frame(4'h1, 2'b10, 3, 0, 0);
		chk("local_ready_first", lrdy, 2'b01);
		frame(4'h6, 2'b11, 2, 0, 0);
		chk("local_ready", lrdy, 2'b11);
		@(posedge clk) obnf <= 2'b01;
		repeat (4) @(posedge clk);
		chk("local_ready_gated", lrdy, 2'b10);
		@(posedge clk) obnf <= 2'b00;
		chk("present_n_mark", pn, 2'b10);
		chk("nearly_full", nf, 2'b01);
		chk("drained_busy", dr, 2'b00);
		chk("no_errors", seen, 6'h00);
		while (dq.size() > 0) begin
			rtick(0, 1'b1);
			chk("data_word", wb0, dq.pop_front());
		end
		while (cq.size() > 0) begin
			rtick(1, 1'b1);
			chk("ctrl_word", wb1, cq.pop_front());
		end
		chk("drained_empty", dr, 2'b11);
		for (int q = 0; q < 2; q++) begin
			clear_seen();
			rtick(q, 1'b0);
			chk("idle_read", seen, 6'h00);
			rtick(q, 1'b1);
			chk("underflow", seen, (q == 0) ? 6'h10 : 6'h04);
		end
		@(posedge clk) hen <= 1'b0;
		clear_seen();
		frame(4'h1, 2'b11, 2, 1, 0);
		chk("hpar_off", seen, 6'h00);
		@(posedge clk) hen <= 1'b1;
		frame(4'h1, 2'b11, 2, 1, 0);
		chk("hpar_on", seen, 6'h02);
		clear_seen();
		frame(4'h2, 2'b11, 2, 0, 1);
		chk("vpar_on", seen, 6'h01);
		clear_seen();
		frame(4'h3, 2'b11, 260, 0, 0);
		chk("overflow", seen, 6'h20);
		@(posedge clk) reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("reset_state", {dr, pn, nf, lrdy}, 8'hf0);
		@(posedge clk) reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk("after_reset", {dr, pn, nf, lrdy}, 8'hf0);
		complete_run();
	end
endmodule
